//--- logic/sram_ctl_map.vh
// Summary of operation
// [R1] Strobe falling edge latches address, starts cycle
// [R2] Address held stable over setup and hold
// [R3] Read data sampled only after access time
// [R4] Write strobe stays high during pure reads
// [R5] Strobe high turns device outputs off
// [R6] Drive write data after write-to-data delay
// [R7] Late write rise may re-enable device outputs
// [R8] Write-first style keeps device outputs off
// [R9] Meet write/strobe intervals, data to strobe rise
// [R10] Both strobes low stores bus data
// [R11] Consecutive writes may hold write strobe low
// [R12] Read-modify-write inside one strobe cycle
// [R13] Any read/write mix while strobe low
// [R14] 1024 words of 4 bits, ten address bits
// [R15] Fully static, controller may idle freely
// [R16] Internal latch and gate from chip strobe
// [R17] Strobe high: no writes, no bus drive
`ifndef SRAM_CTL_MAP_VH
`define SRAM_CTL_MAP_VH

// ----------------------------------------
// Geometry
// ----------------------------------------
`define ADDR_W 10
`define DATA_W 4

// ----------------------------------------
// Timing in ns, slow speed grade
// ----------------------------------------
`define CLK_NS 4
`define T_SETUP_NS 20
`define T_HOLD_NS 50
`define T_ACCESS_NS 350
`define T_STROBE_LOW_NS 350
`define T_STROBE_HIGH_NS 150
`define T_WRITE_PULSE_NS 350
`define T_WRITE_TO_DATA_NS 100
`define T_DATA_SETUP_NS 250
`define T_OUTPUT_OFF_NS 100
`define T_CYCLE_NS 500

// Cycle counts: least times round up
`define CYC(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_READ 2'h0
`define CMD_WRITE 2'h1
`define CMD_RMW 2'h2

`endif

//--- logic/cycle_timer.v
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Down counter; done when zero
// ----------------------------------------
module cycle_timer #(
    parameter W = 8
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire load_i,
    input wire [W-1:0] value_i,
    output wire done_o
);
    reg [W-1:0] count; // Cycles left

    // Load wins over counting
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
            count <= {W{1'b0}};
        else if (load_i)
            count <= value_i;
        else if (count != {W{1'b0}})
            count <= count - {{(W-1){1'b0}}, 1'b1};
    end

    assign done_o = (count == {W{1'b0}});
endmodule
`default_nettype wire

//--- logic/sram_ctl.v
`timescale 1ns/100ps
`default_nettype none
`include "sram_ctl_map.vh"
module sram_ctl #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W
) (
    input wire clk_sys_i,
    input wire rst_i,
    input wire req_valid_i,
    output wire req_ready_o,
    input wire [1:0] req_cmd_i,
    input wire [AW-1:0] req_addr_i,
    input wire [DW-1:0] req_wdata_i,
    output reg rsp_valid_o,
    output reg [DW-1:0] rsp_rdata_o,
    output reg mem_strobe_n_o,
    output reg mem_write_n_o,
    output reg [AW-1:0] mem_addr_o,
    input wire [DW-1:0] mem_dq_i,
    output reg [DW-1:0] mem_dq_o,
    output reg mem_dq_oe_o
);
    // ----------------------------------------
    // Cycle counts
    // ----------------------------------------
    // Whole counts first, then cut to the timer width on purpose
    localparam integer N_SETUP = `CYC(`T_SETUP_NS);
    localparam integer N_HOLD = `CYC(`T_HOLD_NS);
    localparam integer N_ACCESS = `CYC(`T_ACCESS_NS);
    localparam integer N_SLOW = `CYC(`T_STROBE_LOW_NS);
    localparam integer N_WPULSE = `CYC(`T_WRITE_PULSE_NS);
    localparam integer N_W2D = `CYC(`T_WRITE_TO_DATA_NS);
    localparam integer N_DSETUP = `CYC(`T_DATA_SETUP_NS);
    localparam integer N_SHIGH = `CYC(`T_STROBE_HIGH_NS);
    localparam integer N_OFF = `CYC(`T_OUTPUT_OFF_NS);
    localparam integer N_CYCLE = `CYC(`T_CYCLE_NS);
    localparam [7:0] C_SETUP = N_SETUP[7:0];
    localparam [7:0] C_HOLD = N_HOLD[7:0];
    // Two sync stages cost two cycles; the timer load handshake cycles keep access long enough
    localparam [7:0] C_ACCESS = N_ACCESS[7:0];
    localparam [7:0] C_SLOW = N_SLOW[7:0]; // Least strobe low width
    localparam [7:0] C_WPULSE = N_WPULSE[7:0];
    localparam [7:0] C_W2D = N_W2D[7:0];
    localparam [7:0] C_DSETUP = N_DSETUP[7:0];
    localparam [7:0] C_SHIGH = N_SHIGH[7:0];
    localparam [7:0] C_OFF = N_OFF[7:0];
    localparam [7:0] C_CYCLE = N_CYCLE[7:0];

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [3:0] S_IDLE = 4'h0;
    localparam [3:0] S_SETUP = 4'h1;
    localparam [3:0] S_HOLD = 4'h2;
    localparam [3:0] S_ACCESS = 4'h3;
    localparam [3:0] S_WLOW = 4'h4;
    localparam [3:0] S_WDATA = 4'h5;
    localparam [3:0] S_RISE = 4'h6;
    localparam [3:0] S_RECOVER = 4'h7;
    localparam [3:0] S_WSET = 4'h8;

    reg [3:0] state; // Sequencer state
    reg [1:0] cmd; // Command in progress
    reg [DW-1:0] wdata; // Write data held for the cycle
    reg [DW-1:0] dq_meta; // First sync stage
    reg [DW-1:0] dq_sync; // Second sync stage
    reg load; // Timer load strobe
    reg [7:0] load_val; // Timer load value
    reg [7:0] cyc_left; // Cycle-time tracker
    wire t_done; // Phase timer expired

    // ----------------------------------------
    // Phase timer
    // ----------------------------------------
    cycle_timer #(
        .W(8)
    ) u_timer (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(load),
        .value_i(load_val),
        .done_o(t_done)
    );

    // Idle accepts only once strobe recovery and cycle time are met
    assign req_ready_o = (state == S_IDLE) && t_done &&
        (cyc_left == 8'h00);

    // Read bus passes two flops before use
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            dq_meta <= {DW{1'b0}};
            dq_sync <= {DW{1'b0}};
        end
        else
        begin
            dq_meta <= mem_dq_i;
            dq_sync <= dq_meta;
        end
    end

    // Whole-cycle timer from the strobe fall
    always @(posedge clk_sys_i)
    begin
        if (rst_i)
            cyc_left <= 8'h00;
        else if (state == S_HOLD && load)
            cyc_left <= C_CYCLE - C_HOLD;
        else if (cyc_left != 8'h00)
            cyc_left <= cyc_left - 8'h01;
    end

    // ----------------------------------------
    // Sequencer
    // ----------------------------------------
    // Static host: it may idle in S_IDLE forever [R15]
    always @(posedge clk_sys_i)
    begin
        load <= 1'b0;
        load_val <= 8'h00;
        rsp_valid_o <= 1'b0;
        if (rst_i)
        begin
            state <= S_IDLE;
            cmd <= `CMD_READ;
            wdata <= {DW{1'b0}};
            mem_strobe_n_o <= 1'b1;
            mem_write_n_o <= 1'b1;
            mem_addr_o <= {AW{1'b0}};
            mem_dq_o <= {DW{1'b0}};
            mem_dq_oe_o <= 1'b0;
            rsp_rdata_o <= {DW{1'b0}};
        end
        else
        begin
            case (state)
                S_IDLE:
                begin
                    // Strobe high: no bus drive here [R17]
                    if (req_valid_i && req_ready_o)
                    begin
                        cmd <= req_cmd_i;
                        wdata <= req_wdata_i;
                        mem_addr_o <= req_addr_i; // [R14]
                        load <= 1'b1;
                        if (req_cmd_i == `CMD_WRITE)
                        begin
                            // Write-first style: write strobe before
                            // strobe fall, so device stays off [R8] [R9]
                            mem_write_n_o <= 1'b0;
                            mem_dq_o <= req_wdata_i;
                            mem_dq_oe_o <= 1'b1;
                            load_val <= C_SETUP;
                            state <= S_WSET;
                        end
                        else
                        begin
                            mem_write_n_o <= 1'b1; // [R4]
                            load_val <= C_SETUP;
                            state <= S_SETUP;
                        end
                    end
                end
                S_WSET, S_SETUP:
                begin
                    // Address setup before strobe fall [R2]
                    if (t_done && !load)
                    begin
                        mem_strobe_n_o <= 1'b0; // [R1] [R16]
                        load <= 1'b1;
                        load_val <= C_HOLD;
                        state <= S_HOLD;
                    end
                end
                S_HOLD:
                begin
                    // Address kept through hold; could change after [R2]
                    if (t_done && !load)
                    begin
                        load <= 1'b1;
                        if (cmd == `CMD_WRITE)
                        begin
                            // Strobe and write both low store data [R10];
                            // low time covers strobe width and data setup
                            load_val <= (C_SLOW - C_HOLD > C_DSETUP) ?
                                C_SLOW - C_HOLD : C_DSETUP;
                            state <= S_RISE;
                        end
                        else
                        begin
                            load_val <= C_ACCESS - C_HOLD;
                            state <= S_ACCESS;
                        end
                    end
                end
                S_ACCESS:
                begin
                    // Sample only after access time [R3]
                    if (t_done && !load)
                    begin
                        rsp_rdata_o <= dq_sync;
                        load <= 1'b1;
                        if (cmd == `CMD_RMW)
                        begin
                            // Write strobe low turns device off [R6] [R12]
                            mem_write_n_o <= 1'b0;
                            load_val <= C_W2D;
                            state <= S_WLOW;
                        end
                        else
                        begin
                            rsp_valid_o <= 1'b1;
                            load_val <= 8'h01;
                            state <= S_RISE;
                        end
                    end
                end
                S_WLOW:
                begin
                    // Bus driven only after write-to-data delay [R6]
                    if (t_done && !load)
                    begin
                        mem_dq_o <= wdata;
                        mem_dq_oe_o <= 1'b1;
                        load <= 1'b1;
                        load_val <= (C_WPULSE > C_DSETUP + C_W2D) ?
                            C_WPULSE - C_W2D : C_DSETUP;
                        state <= S_WDATA;
                    end
                end
                S_WDATA:
                begin
                    // Write pulse ends; data stops with it [R12] [R13]
                    if (t_done && !load)
                    begin
                        mem_write_n_o <= 1'b1;
                        mem_dq_oe_o <= 1'b0;
                        rsp_rdata_o <= wdata;
                        rsp_valid_o <= 1'b1;
                        load <= 1'b1;
                        // Device may drive again before strobe rise [R7]
                        load_val <= 8'h01;
                        state <= S_RISE;
                    end
                end
                S_RISE:
                begin
                    // Strobe rises; on a plain write, write strobe rises after it [R9]
                    if (t_done && !load)
                    begin
                        mem_strobe_n_o <= 1'b1;
                        if (cmd == `CMD_WRITE)
                            rsp_valid_o <= 1'b1;
                        load <= 1'b1;
                        load_val <= (C_OFF > C_SHIGH) ? C_OFF : C_SHIGH;
                        state <= S_RECOVER;
                    end
                end
                S_RECOVER:
                begin
                    // Release bus; device output-off wait is timed in S_IDLE via ready [R5] [R17]
                    mem_write_n_o <= 1'b1;
                    mem_dq_oe_o <= 1'b0;
                    if (!load)
                        state <= S_IDLE; // [R11]
                end
                default:
                begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

//--- dv/sram_ctl_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Pin timing checks on the controller
// ----------------------------------------
module sram_ctl_asserts #(
    parameter AW = 10,
    parameter DW = 4
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic req_ready_o,
    input wire logic mem_strobe_n_o,
    input wire logic mem_write_n_o,
    input wire logic [AW-1:0] mem_addr_o,
    input wire logic [DW-1:0] mem_dq_o,
    input wire logic mem_dq_oe_o
);
    logic [7:0] low_cnt; // Cycles strobe low
    logic [7:0] high_cnt; // Cycles strobe high
    logic [7:0] wlow_cnt; // Cycles write low
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // Saturating run lengths; high starts full, reset leaves strobe idle
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            low_cnt <= 8'h00;
            high_cnt <= 8'hFF;
            wlow_cnt <= 8'h00;
        end
        else
        begin
            low_cnt <= mem_strobe_n_o ? 8'h00 : low_cnt + {7'h0, ~&low_cnt};
            high_cnt <= !mem_strobe_n_o ? 8'h00 :
                high_cnt + {7'h0, ~&high_cnt};
            wlow_cnt <= mem_write_n_o ? 8'h00 :
                wlow_cnt + {7'h0, ~&wlow_cnt};
        end
    end
    a_oe_needs_write: assert property (mem_dq_oe_o |-> !mem_write_n_o)
        else $error("host drives bus with write high");
    a_addr_setup: assert property ($fell(mem_strobe_n_o) |->
        mem_addr_o == $past(mem_addr_o, 4)) else $error("address setup");
    a_addr_hold: assert property ($fell(mem_strobe_n_o) |=>
        $stable(mem_addr_o) [*8]) else $error("address hold");
    a_strobe_width: assert property ($rose(mem_strobe_n_o) |->
        low_cnt >= 8'd88) else $error("strobe low too short");
    a_strobe_rest: assert property ($fell(mem_strobe_n_o) |->
        high_cnt >= 8'd38) else $error("strobe high too short");
    a_write_first: assert property ($fell(mem_strobe_n_o) &&
        !mem_write_n_o |-> !mem_write_n_o [*8]) else $error("write order");
    a_data_hold: assert property ($rose(mem_strobe_n_o) &&
        !mem_write_n_o |=> $stable(mem_dq_o) && mem_write_n_o)
        else $error("write data hold");
    a_write_pulse: assert property ($rose(mem_write_n_o) &&
        !mem_strobe_n_o |-> wlow_cnt >= 8'd88) else $error("write pulse");
    a_idle_quiet: assert property (req_ready_o |->
        mem_strobe_n_o && !mem_dq_oe_o) else $error("idle not quiet");
endmodule
bind sram_ctl sram_ctl_asserts #(.AW(AW), .DW(DW)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_ready_o(req_ready_o),
    .mem_strobe_n_o(mem_strobe_n_o), .mem_write_n_o(mem_write_n_o),
    .mem_addr_o(mem_addr_o), .mem_dq_o(mem_dq_o),
    .mem_dq_oe_o(mem_dq_oe_o));
`default_nettype wire

//--- dv/sram_dev_model.sv
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// Latched-address static memory
// ----------------------------------------
module sram_dev_model (
    input wire logic clk_sys_i,
    input wire logic strobe_n_i,
    input wire logic write_n_i,
    input wire logic [9:0] addr_i,
    input wire logic [3:0] host_dq_i,
    input wire logic host_oe_i,
    output logic [3:0] dq_o,
    output logic clash_o
);
    logic [3:0] mem [0:1023];
    logic [9:0] addr_l; // Latched address
    logic [7:0] acc_cnt; // Cycles since strobe fell
    logic [7:0] wl_cnt; // Cycles write low inside a strobe
    logic read_first; // Strobe fell with write high
    logic [3:0] last = 4'h5; // Last bus level
    logic drive; // Device outputs on
    // Address latch on strobe fall, no clock involved
    always @(negedge strobe_n_i) addr_l <= addr_i;
    // Outputs linger 100 ns after write falls when strobe fell first
    assign drive = !strobe_n_i && (write_n_i || (read_first &&
        wl_cnt < 8'd25));
    assign clash_o = drive && host_oe_i;
    // Undriven bus toggles so a stale value never looks valid
    always_comb
    begin
        if (host_oe_i)
            dq_o = host_dq_i;
        else if (drive && acc_cnt >= 8'd88)
            dq_o = mem[addr_l];
        else
            dq_o = ~last;
    end
    // Access timer and array store while both strobes low and host drives
    always @(posedge clk_sys_i)
    begin
        acc_cnt <= strobe_n_i ? 8'h00 : acc_cnt + {7'h0, ~&acc_cnt};
        wl_cnt <= (strobe_n_i || write_n_i) ? 8'h00 :
            wl_cnt + {7'h0, ~&wl_cnt};
        read_first <= !strobe_n_i && (read_first || write_n_i);
        last <= dq_o;
        if (!strobe_n_i && !write_n_i && host_oe_i)
            mem[addr_l] <= host_dq_i;
    end
endmodule
`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "sram_ctl_map.vh"
module tb;
    logic clk_sys_i = 1'b0;
    logic rst_i, req_valid_i, req_ready_o, rsp_valid_o;
    logic [1:0] req_cmd_i;
    logic [9:0] req_addr_i, mem_addr_o;
    logic [3:0] req_wdata_i, rsp_rdata_o, mem_dq_i, mem_dq_o, q;
    logic mem_strobe_n_o, mem_write_n_o, mem_dq_oe_o, clash;
    int fail_count = 0;
    int n_compared = 0;
    always #2 clk_sys_i = ~clk_sys_i;
    sram_ctl uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
        .req_valid_i(req_valid_i), .req_ready_o(req_ready_o),
        .req_cmd_i(req_cmd_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .rsp_valid_o(rsp_valid_o),
        .rsp_rdata_o(rsp_rdata_o), .mem_strobe_n_o(mem_strobe_n_o),
        .mem_write_n_o(mem_write_n_o), .mem_addr_o(mem_addr_o),
        .mem_dq_i(mem_dq_i), .mem_dq_o(mem_dq_o), .mem_dq_oe_o(mem_dq_oe_o));
    sram_dev_model dev (.clk_sys_i(clk_sys_i), .strobe_n_i(mem_strobe_n_o),
        .write_n_i(mem_write_n_o), .addr_i(mem_addr_o),
        .host_dq_i(mem_dq_o), .host_oe_i(mem_dq_oe_o), .dq_o(mem_dq_i),
        .clash_o(clash));
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task cmp4(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("[FAIL] %s exp %h got %h", what, exp, got);
            fail_count++;
        end
    endtask
    // One request; holds valid until the taking edge, waits bounded
    task op(input logic [1:0] c, input logic [9:0] a, input logic [3:0] d);
        int n;
        for (n = 0; n < 400 && req_ready_o !== 1'b1; n++)
            @(negedge clk_sys_i);
        req_cmd_i = c;
        req_addr_i = a;
        req_wdata_i = d;
        req_valid_i = 1'b1;
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        for (n = 0; n < 400 && rsp_valid_o !== 1'b1; n++)
            @(negedge clk_sys_i);
        cmp4("rsp_valid", 4'h1, {3'h0, rsp_valid_o});
        q = rsp_rdata_o;
    endtask
    task test_done;
        if (fail_count == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // Host and device never drive the bus together
    always @(negedge clk_sys_i)
        if (clash === 1'b1)
            cmp4("bus_clash", 4'h0, 4'h1);
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // End addresses and a rewrite, then read both ends back
    task t_rw;
        op(`CMD_WRITE, 10'h000, 4'h1);
        op(`CMD_WRITE, 10'h000, 4'hA);
        op(`CMD_WRITE, 10'h3FF, 4'h5);
        op(`CMD_WRITE, 10'h155, 4'hF);
        op(`CMD_READ, 10'h000, 4'h0);
        cmp4("rd_000", 4'hA, q);
        op(`CMD_READ, 10'h3FF, 4'h0);
        cmp4("rd_3FF", 4'h5, q);
    endtask
    // Read-modify-write returns new data; code 3 reads
    task t_rmw;
        op(`CMD_WRITE, 10'h2AA, 4'h3);
        op(`CMD_RMW, 10'h2AA, 4'h9);
        cmp4("rmw_rsp", 4'h9, q);
        op(2'h3, 10'h2AA, 4'h0);
        cmp4("rd_2AA", 4'h9, q);
    endtask
    // Reset before strobe falls stores nothing; long idle keeps data
    task t_reset_idle;
        int n;
        // Wait for idle so the write is really taken before reset
        for (n = 0; n < 400 && req_ready_o !== 1'b1; n++)
            @(negedge clk_sys_i);
        req_cmd_i = `CMD_WRITE;
        req_addr_i = 10'h155;
        req_wdata_i = 4'h2;
        req_valid_i = 1'b1;
        @(negedge clk_sys_i);
        req_valid_i = 1'b0;
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        cmp4("rst_pins", 4'h6, {1'b0, mem_strobe_n_o, mem_write_n_o,
            mem_dq_oe_o});
        rst_i = 1'b0;
        repeat (2000) @(negedge clk_sys_i);
        op(`CMD_READ, 10'h155, 4'h0);
        cmp4("rd_155", 4'hF, q);
    endtask
    initial
    begin
        rst_i = 1'b1;
        req_valid_i = 1'b0;
        req_cmd_i = 2'h0;
        req_addr_i = 10'h000;
        req_wdata_i = 4'h0;
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
        t_rw;
        t_rmw;
        t_reset_idle;
        test_done;
    end
    // Watchdog well beyond about 3500 cycles of traffic
    initial
    begin
        #(4 * 20000);
        fail_count++;
        test_done;
    end
endmodule
`default_nettype wire
